//--- rtl/bsfm_top.sv
// Bias supervisor, block enable decoder, fault manager and status serial port
`timescale 1ns/1ps
`include "bsfm_regs.svh"

module bsfm_top #(
    parameter logic [14:0] BIT_CYCLES = 15'(`BSFM_BIT_CYCLES)
) (
    // Clock, reset, clock enable
    input  wire logic                core_clk_i,
    input  wire logic                rstn_i,
    input  wire logic                clk_en_i,
    // APB slave
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [11:0]         paddr_i,
    input  wire logic [31:0]         pwdata_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    // Pins and analog comparators
    input  wire logic                chip_en_i,
    input  wire logic                lin_variant_i,
    input  wire bsfm_pkg::bsfm_cmp_s cmp_i,
    // Block enables
    output bsfm_pkg::bsfm_en_s       en_o,
    // Open-drain limit/fault pin
    output logic                     limit_fault_out_o,
    output logic                     limit_fault_out_oe_o,
    // Open-drain status serial port
    input  wire logic                status_serial_port_i,
    output logic                     status_serial_port_o,
    output logic                     status_serial_port_oe_o
);
    import bsfm_pkg::*;

    // ======================================================================
    // Input synchronisers
    bsfm_cmp_s cmp_m_q, cmp_q;
    logic      ce_m_q, ce_q, ser_m_q, ser_q, var_m_q, var_q;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmp_m_q <= '0;
            cmp_q   <= '0;
            ce_m_q  <= 1'b0;
            ce_q    <= 1'b0;
            ser_m_q <= 1'b1;
            ser_q   <= 1'b1;
        end else if (clk_en_i) begin
            cmp_m_q <= cmp_i;
            cmp_q   <= cmp_m_q;
            ce_m_q  <= chip_en_i;
            ce_q    <= ce_m_q;
            ser_m_q <= status_serial_port_i;
            ser_q   <= ser_m_q;
        end
    end

    // Variant strap is a pin too, so it gets two flops like the rest
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            var_m_q <= 1'b0;
            var_q   <= 1'b0;
        end else if (clk_en_i) begin
            var_m_q <= lin_variant_i;
            var_q   <= var_m_q;
        end
    end

    // ======================================================================
    // APB slave
    logic [7:0] status_reg_zero_q, status_reg_one_q, ctrl_q;
    bsfm_en_s   en_q;
    logic       rd_err_q;
    logic       setup, access, hit;

    assign setup  = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    assign hit    = (paddr_i == `BSFM_STATUS_REG_ZERO_OFF) || (paddr_i == `BSFM_STATUS_REG_ONE_OFF) ||
                    (paddr_i == `BSFM_CTRL_OFF)  || (paddr_i == `BSFM_ENAB_OFF);
    // One wait-free access phase; data captured in setup so it comes from a flop
    assign pready_o  = penable_i;
    assign pslverr_o = access && rd_err_q;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h0000_0000;
            rd_err_q <= 1'b0;
        end else if (clk_en_i && setup) begin
            rd_err_q <= !hit;
            unique case (paddr_i)
                `BSFM_STATUS_REG_ZERO_OFF: prdata_o <= {24'h000000, status_reg_zero_q};
                `BSFM_STATUS_REG_ONE_OFF: prdata_o <= {24'h000000, status_reg_one_q};
                `BSFM_CTRL_OFF:  prdata_o <= {24'h000000, ctrl_q};
                `BSFM_ENAB_OFF:  prdata_o <= {23'h000000, en_q};
                default:         prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    logic wr_ctrl, wr_status_reg_one;
    assign wr_ctrl  = clk_en_i && access && pwrite_i && (paddr_i == `BSFM_CTRL_OFF);
    assign wr_status_reg_one = clk_en_i && access && pwrite_i && (paddr_i == `BSFM_STATUS_REG_ONE_OFF);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q <= `BSFM_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= {7'h00, pwdata_i[`BSFM_CTRL_SLEEP]};
        end
    end

    // ======================================================================
    // Warning and fault flags
    logic [7:0] status_reg_zero_d;
    logic       fault_any;

    always_comb begin
        status_reg_zero_d = status_reg_zero_q;
        status_reg_zero_d[`BSFM_S0_OCW] = cmp_q.buck_ioc;
        if (cmp_q.buck_lt_90) begin
            status_reg_zero_d[`BSFM_S0_LOWW] = 1'b1;
        end else if (cmp_q.buck_ge_94) begin
            status_reg_zero_d[`BSFM_S0_LOWW] = 1'b0;
        end
        // Lockout holds until chip-enable drops, since a stopped buck stays low
        if ((ce_q && cmp_q.buck_lt_80) || cmp_q.vdd_lt_buck_stop) begin
            status_reg_zero_d[`BSFM_S0_LOCK] = 1'b1;
        end else if (!ce_q) begin
            status_reg_zero_d[`BSFM_S0_LOCK] = 1'b0;
        end
        status_reg_zero_d[`BSFM_S0_DRVUV] = cmp_q.vdd_lt_5v5;
        status_reg_zero_d[`BSFM_S0_DRVOV] = var_q && cmp_q.vdd_gt_20v;
        status_reg_zero_d[`BSFM_S0_SYSOV] = cmp_q.vdd_gt_32v;
        if (cmp_q.tj_gt_sd) begin
            status_reg_zero_d[`BSFM_S0_OTF] = 1'b1;
        end else if (!ce_q && cmp_q.tj_below_hyst) begin
            status_reg_zero_d[`BSFM_S0_OTF] = 1'b0;
        end
        status_reg_zero_d[7] = 1'b0;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_reg_zero_q <= 8'h00;
        end else if (clk_en_i) begin
            status_reg_zero_q <= status_reg_zero_d;
        end
    end

    // Config-lost: reset value set, write-one clears, new brown-out wins
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_reg_one_q <= `BSFM_STATUS_REG_ONE_RST;
        end else if (clk_en_i) begin
            status_reg_one_q[`BSFM_S1_THW] <= cmp_q.tj_gt_warn;
            if (cmp_q.vdd_lt_3v8) begin
                status_reg_one_q[`BSFM_S1_CFGL] <= 1'b1;
            end else if (wr_status_reg_one && pwdata_i[`BSFM_S1_CFGL]) begin
                status_reg_one_q[`BSFM_S1_CFGL] <= 1'b0;
            end
        end
    end

    assign fault_any = |status_reg_zero_q[6:2] || cmp_q.ldo5_uv || cmp_q.mosfet_uv ||
                       cmp_q.mosfet_oc;

    // ======================================================================
    // Block enables
    bsfm_en_s en_d;
    logic     sys_off;

    assign sys_off = status_reg_zero_q[`BSFM_S0_OTF] || status_reg_zero_q[`BSFM_S0_SYSOV];

    always_comb begin
        en_d = '0;
        if (!ce_q && ctrl_q[`BSFM_CTRL_SLEEP]) begin
            en_d.lin_wake = 1'b1;
        end else if (!ce_q) begin
            en_d.ldo5        = var_q;
            en_d.buck        = 1'b1;
            en_d.lin_on      = !var_q;
            en_d.lin_rx_only = var_q;
            en_d.port        = 1'b1;
        end else begin
            // Warnings alone change nothing here
            en_d.ldo5    = 1'b1;
            en_d.buck    = 1'b1;
            en_d.lin_on  = 1'b1;
            en_d.ldo12   = 1'b1;
            en_d.drivers = !fault_any;
            en_d.port    = 1'b1;
            if (status_reg_zero_q[`BSFM_S0_DRVUV] || status_reg_zero_q[`BSFM_S0_LOCK]) begin
                en_d.ldo5   = 1'b0;
                en_d.lin_on = 1'b0;
                en_d.ldo12  = 1'b0;
            end
            if (cmp_q.ldo5_uv) begin
                en_d.lin_on      = 1'b0;
                en_d.lin_rx_only = 1'b1;
            end
        end
        if (status_reg_zero_q[`BSFM_S0_LOCK] || cmp_q.vdd_gt_buck_ov) begin
            en_d.buck = 1'b0;
        end
        if (cmp_q.vdd_lt_buck_stop) begin
            en_d = '0;
            en_d.port = ce_q || !ctrl_q[`BSFM_CTRL_SLEEP];
        end
        if (sys_off) begin
            en_d = '0;
            en_d.port = ce_q || !ctrl_q[`BSFM_CTRL_SLEEP];
        end
        en_d.pump = en_d.ldo12 && cmp_q.vdd_lt_pump && !cmp_q.vdd_in_12v_band;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            en_q <= '0;
        end else if (clk_en_i) begin
            en_q <= en_d;
        end
    end
    assign en_o = en_q;

    // Fault pin pulls low while chip-enable is high and a fault stands
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            limit_fault_out_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            limit_fault_out_oe_o <= ce_q && fault_any;
        end
    end
    assign limit_fault_out_o = 1'b0;

    // ======================================================================
    // Message requests: rising status zero flags or thermal warning queue a status message
    logic [7:0] status_reg_zero_prev_q;
    logic       thw_prev_q, pend0_q, pend1_q, take0, take1;
    bsfm_tx_e   tx_q;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_reg_zero_prev_q <= 8'h00;
            thw_prev_q   <= 1'b0;
            pend0_q      <= 1'b0;
            pend1_q      <= 1'b0;
        end else if (clk_en_i) begin
            status_reg_zero_prev_q <= status_reg_zero_q;
            thw_prev_q   <= status_reg_one_q[`BSFM_S1_THW];
            // New event beats the acceptance of an older one
            if (|(status_reg_zero_q & ~status_reg_zero_prev_q)) begin
                pend0_q <= 1'b1;
            end else if (take0) begin
                pend0_q <= 1'b0;
            end
            if (status_reg_one_q[`BSFM_S1_THW] && !thw_prev_q) begin
                pend1_q <= 1'b1;
            end else if (take1) begin
                pend1_q <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Line idle detect: host frames keep the port busy
    logic [14:0] idle_cnt_q;
    logic [3:0]  idle_bits_q;
    logic        line_idle;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            idle_cnt_q  <= 15'h0000;
            idle_bits_q <= 4'h0;
        end else if (clk_en_i) begin
            if (!ser_q && tx_q == TX_IDLE) begin
                idle_cnt_q  <= 15'h0000;
                idle_bits_q <= 4'h0;
            end else if (idle_bits_q != `BSFM_IDLE_BITS) begin
                if (idle_cnt_q == BIT_CYCLES - 15'h0001) begin
                    idle_cnt_q  <= 15'h0000;
                    idle_bits_q <= idle_bits_q + 4'h1;
                end else begin
                    idle_cnt_q <= idle_cnt_q + 15'h0001;
                end
            end
        end
    end
    assign line_idle = (idle_bits_q == `BSFM_IDLE_BITS);

    // ======================================================================
    // Transmitter: id byte, then register byte, 8N1, LSB first
    logic [14:0] baud_q;
    logic [2:0]  bit_q;
    logic [7:0]  sh_q, second_q;
    logic        second_pend_q;
    logic        bit_end, start_ok;

    assign bit_end  = (baud_q == BIT_CYCLES - 15'h0001);
    assign start_ok = (tx_q == TX_IDLE) && line_idle;
    assign take0    = clk_en_i && start_ok && !second_pend_q && pend0_q;
    assign take1    = clk_en_i && start_ok && !second_pend_q && !pend0_q && pend1_q;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_q          <= TX_IDLE;
            baud_q        <= 15'h0000;
            bit_q         <= 3'h0;
            sh_q          <= 8'h00;
            second_q      <= 8'h00;
            second_pend_q <= 1'b0;
        end else if (clk_en_i) begin
            baud_q <= (tx_q == TX_IDLE || bit_end) ? 15'h0000 : baud_q + 15'h0001;
            unique case (tx_q)
                TX_IDLE: begin
                    if (start_ok && second_pend_q) begin
                        sh_q          <= second_q;
                        second_pend_q <= 1'b0;
                        tx_q          <= TX_START;
                    end else if (take0 || take1) begin
                        sh_q          <= take0 ? `BSFM_MSG0_ID : `BSFM_MSG1_ID;
                        second_q      <= take0 ? status_reg_zero_q : status_reg_one_q;
                        second_pend_q <= 1'b1;
                        tx_q          <= TX_START;
                    end
                end
                TX_START: begin
                    if (bit_end) begin
                        bit_q <= 3'h0;
                        tx_q  <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (bit_end) begin
                        sh_q  <= {1'b0, sh_q[7:1]};
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            tx_q <= TX_STOP;
                        end
                    end
                end
                TX_STOP: begin
                    if (bit_end) begin
                        tx_q <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // Pin only ever pulled low; high is the external pull-up
    assign status_serial_port_o    = 1'b0;
    assign status_serial_port_oe_o = (tx_q == TX_START) ||
                                     (tx_q == TX_DATA && !sh_q[0]);

    // ======================================================================
    // Assertions
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_lock_cause;
        clk_en_i && ce_q && cmp_q.buck_lt_80;
    endsequence
    sequence s_lock_seen;
        clk_en_i ##1 clk_en_i;
    endsequence

    a_ldo12_ce_off: assert property (!$past(ce_q) && $past(clk_en_i) |-> !en_q.ldo12)
        else $error("12 V regulator on with chip-enable low");
    a_pump_band: assert property (en_q.pump |-> !$past(cmp_q.vdd_in_12v_band))
        else $error("Pump on inside direct-feed band");
    a_pump_start: assert property (clk_en_i && en_d.ldo12 && cmp_q.vdd_lt_pump &&
        !cmp_q.vdd_in_12v_band |=> en_q.pump)
        else $error("Pump not started below start level");
    a_ldo5_sleep: assert property (clk_en_i && !ce_q && ctrl_q[0] |=> !en_q.ldo5)
        else $error("5 V regulator on in sleep");
    a_ocw_track: assert property (clk_en_i && cmp_q.buck_ioc |=> status_reg_zero_q[0])
        else $error("Overcurrent warning missed");
    a_low_hyst: assert property (clk_en_i && status_reg_zero_q[1] && !cmp_q.buck_ge_94 |=> status_reg_zero_q[1])
        else $error("Low-output warning cleared before 94 percent");
    a_lock_off: assert property (s_lock_cause ##1 s_lock_seen |-> !en_q.buck &&
        limit_fault_out_oe_o)
        else $error("Buck lockout did not stop buck and pull fault pin");
    a_buck_ov: assert property (clk_en_i && cmp_q.vdd_gt_buck_ov |=> !en_q.buck)
        else $error("Buck running above overvoltage stop level");
    a_sys_ov: assert property (clk_en_i && cmp_q.vdd_gt_32v ##1 clk_en_i |=>
        !en_q.drivers && !en_q.buck && !en_q.ldo5)
        else $error("Functions left on above 32 V");
    a_warn_quiet: assert property (clk_en_i && ce_q && !fault_any &&
        !cmp_q.vdd_lt_buck_stop |=>
        !limit_fault_out_oe_o && en_q.drivers)
        else $error("Warning disturbed operation");
    a_tx_waits: assert property (tx_q == TX_IDLE && !line_idle |=> tx_q == TX_IDLE)
        else $error("Transmit started on busy line");

endmodule : bsfm_top

//--- pkg/bsfm_regs.svh
// Register offsets, field positions, reset values and timing counts of the bias supervisor
//
// Overview of operation
// - Status port runs half-duplex 8N1 at 9600 baud; one talker at a time.
// - Status port pin is only pulled low, otherwise released to external pull-up.
// - 12 V regulator stays off whenever chip-enable is low.
// - Supply inside the 12 V to 12.7 V band: pump off, regulator fed directly.
// - Supply below pump start level switches the charge pump on while the 12 V regulator is enabled.
// - 5 V regulator off in sleep; in standby on only for LIN variant.
// - Buck overcurrent warning tracks the current comparator and sends status zero.
// - Buck low-output warning sets below 90 percent, clears at 94 percent, sends status.
// - Buck output below 80 percent with chip-enable high: shutdown, lockout fault, status zero, fault pin low.
// - Supply below buck input stop level: buck off, lockout fault, status zero.
// - Supply above buck overvoltage stop level switches the buck off.
// - Config-lost warning sets at power-up and below 3.8 V; host then reconfigures.
// - Drivers off below 5.5 V or above 20 V on LIN variant; status sent.
// - Supply above 32 V turns every function off except the status port, which stays on outside sleep.
// - Supply below 4.0 V disables the buck converter.
// - Overtemperature turns everything off but the status port (on outside sleep) until cooled and chip-enable toggled.
// - Junction above the thermal warning point sends a warning message.
// - Block enables follow chip-enable and sleep: sleep, standby, operating.
// - Chip-enable high with a fault: fault pin low, drivers off, port alive.
// - Warnings leave the fault pin released and every block running.
// - Fault pin held low as long as any fault stays active and chip-enable is high.
`ifndef BSFM_REGS_SVH
`define BSFM_REGS_SVH

// ==========================================================================
// Register map
`define BSFM_STATUS_REG_ZERO_OFF    12'h000
`define BSFM_STATUS_REG_ONE_OFF    12'h004
`define BSFM_CTRL_OFF     12'h008
`define BSFM_ENAB_OFF     12'h00C

// ==========================================================================
// Fields
`define BSFM_S0_OCW       0
`define BSFM_S0_LOWW      1
`define BSFM_S0_LOCK      2
`define BSFM_S0_DRVUV     3
`define BSFM_S0_DRVOV     4
`define BSFM_S0_SYSOV     5
`define BSFM_S0_OTF       6
`define BSFM_S1_CFGL      0
`define BSFM_S1_THW       1
`define BSFM_CTRL_SLEEP   0

// ==========================================================================
// Reset values and message identifiers
`define BSFM_STATUS_REG_ONE_RST    8'h01
`define BSFM_CTRL_RST     8'h00
`define BSFM_MSG0_ID      8'hA0
`define BSFM_MSG1_ID      8'hA1

// ==========================================================================
// Timing
`define BSFM_CLK_HZ       250000000
`define BSFM_BAUD         9600
`define BSFM_BIT_CYCLES   (`BSFM_CLK_HZ / `BSFM_BAUD)
`define BSFM_IDLE_BITS    4'hA

`endif

//--- pkg/bsfm_pkg.sv
// Types shared by the bias supervisor and fault manager
package bsfm_pkg;

    // Synchronised analog comparator outputs
    typedef struct packed {
        logic vdd_lt_3v8;
        logic vdd_lt_buck_stop;
        logic vdd_lt_5v5;
        logic vdd_lt_pump;
        logic vdd_in_12v_band;
        logic vdd_gt_20v;
        logic vdd_gt_buck_ov;
        logic vdd_gt_32v;
        logic buck_ioc;
        logic buck_lt_80;
        logic buck_lt_90;
        logic buck_ge_94;
        logic tj_gt_warn;
        logic tj_gt_sd;
        logic tj_below_hyst;
        logic ldo5_uv;
        logic mosfet_uv;
        logic mosfet_oc;
    } bsfm_cmp_s;

    // Block enables driven to the analog blocks
    typedef struct packed {
        logic ldo5;
        logic buck;
        logic lin_on;
        logic lin_rx_only;
        logic lin_wake;
        logic ldo12;
        logic pump;
        logic drivers;
        logic port;
    } bsfm_en_s;

    typedef enum logic [3:0] {
        TX_IDLE  = 4'h1,
        TX_START = 4'h2,
        TX_DATA  = 4'h4,
        TX_STOP  = 4'h8
    } bsfm_tx_e;

endpackage : bsfm_pkg

//--- bench/bsfm_host.sv
// Host microcontroller model on the open-drain status serial line
`timescale 1ns/1ps
module bsfm_host #(
    parameter int BIT = 8
) (
    // Line and clock
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      oe_o
);
    logic       tx = 1'b0;
    logic [7:0] rxq[$];
    logic [7:0] b;
    initial oe_o = 1'b0;
    // ==========================================
    // Receiver, 8N1 LSB first, sampled mid-bit
    initial forever begin
        @(posedge clk_i);
        if (!line_i && !tx) begin
            repeat (BIT / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk_i);
                b[i] = line_i;
            end
            repeat (BIT) @(posedge clk_i);
            rxq.push_back(b);
        end
    end
    // ==========================================
    // Transmitter, only ever pulls the line low
    task send(input logic [7:0] d);
        tx = 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            oe_o <= (i == 0) ? 1'b1 : (i == 9) ? 1'b0 : ~d[i-1];
            repeat (BIT - 1) @(posedge clk_i);
        end
        tx = 1'b0;
    endtask : send
endmodule : bsfm_host

//--- bench/bsfm_top_tb.sv
// Self-checking bench of the bias supervisor and fault manager
`timescale 1ns/1ps
module bsfm_top_tb;
    import bsfm_pkg::*;
    typedef struct packed {
        logic [17:0] c;
        logic [8:0]  e;
        logic        f;
        logic [7:0]  s;
    } bsfm_row_s;
    localparam logic [17:0] B = 18'h00048;
    localparam bsfm_row_s ROWS[11] = '{
        '{B, 9'h1CB, 1'b0, 8'h00}, '{B | 18'h04000, 9'h1CF, 1'b0, 8'h00},
        '{B | 18'h06000, 9'h1CB, 1'b0, 8'h00}, '{B | 18'h01000, 9'h1C9, 1'b1, 8'h10},
        '{B | 18'h00200, 9'h1CB, 1'b0, 8'h01}, '{B | 18'h00001, 9'h1C9, 1'b1, 8'h00},
        '{B | 18'h08000, 9'h081, 1'b1, 8'h08}, '{B | 18'h00400, 9'h001, 1'b1, 8'h20},
        '{18'h00088, 9'h1CB, 1'b0, 8'h02}, '{18'h00008, 9'h1CB, 1'b0, 8'h02},
        '{B, 9'h1CB, 1'b0, 8'h00}};
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, chip_en = 1, lin = 1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, lf_o, lf_oe, sp_o, sp_oe, host_oe;
    bsfm_cmp_s cmp = B;
    bsfm_en_s  en;
    wire line = ~(sp_oe | host_oe);
    int failures = 0, comparisons = 0;
    always #2 clk = ~clk;
    bsfm_top #(.BIT_CYCLES(15'd8)) dut (.core_clk_i(clk), .rstn_i(rstn), .clk_en_i(1'b1),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .chip_en_i(chip_en), .lin_variant_i(lin), .cmp_i(cmp), .en_o(en),
        .limit_fault_out_o(lf_o), .limit_fault_out_oe_o(lf_oe),
        .status_serial_port_i(line), .status_serial_port_o(sp_o),
        .status_serial_port_oe_o(sp_oe));
    bsfm_host #(.BIT(8)) host (.clk_i(clk), .line_i(line), .oe_o(host_oe));
    // ==========================================
    // Helpers
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) failures++;
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task final_report;
        if (failures == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    // ==========================================
    // Device never talks over the host
    always @(posedge clk) if (host.tx) check(sp_oe, 0);
    initial begin
        tick(40000);
        failures++;
        final_report;
    end
    initial begin
        tick(10);
        rstn <= 1'b1;
        apb(0, 12'h004, 0);
        check(rd, 32'h1);
        apb(0, 12'h010, 0);
        check({er, rd}, {1'b1, 32'h0});
        foreach (ROWS[k]) begin
            @(posedge clk);
            cmp <= ROWS[k].c;
            tick(8);
            check(en, ROWS[k].e);
            check(lf_oe, ROWS[k].f);
            apb(0, 12'h000, 0);
            check(rd, ROWS[k].s);
        end
        apb(0, 12'h00C, 0);
        check(rd, 32'h1CB);
        for (int k = 0; k < 2; k++) begin
            cmp <= k ? 18'h00050 : 18'h00148;
            tick(8);
            check({lf_oe, en.buck}, 2'b10);
            apb(0, 12'h000, 0);
            check({rd[6], rd[2]}, k ? 2'b10 : 2'b01);
            cmp <= B;
            tick(8);
            check(lf_oe, 1);
            chip_en <= 1'b0;
            tick(8);
            chip_en <= 1'b1;
            tick(8);
            check({lf_oe, en}, {1'b0, 9'h1CB});
        end
        for (int v = 0; v < 2; v++) begin
            lin <= v[0];
            chip_en <= 1'b0;
            tick(8);
            check({en.ldo12, en.ldo5, en.buck}, {1'b0, v[0], 1'b1});
            apb(1, 12'h008, 1);
            tick(8);
            check(en, 9'h010);
            apb(1, 12'h008, 0);
        end
        chip_en <= 1'b1;
        lin <= 1'b1;
        apb(1, 12'h004, 1);
        apb(0, 12'h004, 0);
        check(rd, 0);
        cmp <= B | 18'h20000;
        tick(8);
        apb(0, 12'h004, 0);
        check(rd, 1);
        cmp <= B;
        tick(8);
        apb(1, 12'h004, 1);
        tick(1600);
        host.rxq.delete();
        fork
            host.send(8'h3C);
            begin
                tick(20);
                cmp <= B | 18'h00020;
            end
        join
        for (int n = 0; n < 800 && host.rxq.size() < 2; n++) tick(1);
        check(host.rxq[0], 8'hA1);
        check(host.rxq[1], 8'h02);
        final_report;
    end
endmodule : bsfm_top_tb
